// *** cpm_core.sv ***
// Program counter, return stack, shadow registers and indirect pointers with AHB-Lite slave
`default_nettype none

// What this block does
// RULE1: Separate sixteen-entry fifteen-bit return stack.
// RULE2: Full push or empty pop sets flag.
// RULE3: Stack error resets when reset enabled.
// RULE4: Shadow copies saved on interrupt, restored on return.
// RULE5: Two sixteen-bit pointers reach all memory.
// RULE6: Program memory through pointer costs one cycle.
// RULE7: Pointers give linear view of RAM.
// RULE8: Program counter is fifteen bits wide.
// RULE9: Addresses above implemented memory wrap around.
// RULE10: Reset starts at 0000h, interrupt 0004h.
// RULE11: Core executes a forty-nine instruction set. The block only reports 49 at OFF_INFO and decodes twelve commands.
// RULE12: Direct, indirect and relative addressing supported.
// RULE13: Pointer bit 15 reads program word low byte.
// RULE14: Writes toward program memory have no effect.
// RULE15: Fetch address ignores counter bits above eleven.
module cpm_core (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [cpm_pkg::BUS_AW-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Interrupt request from logic on the same clock
  input wire logic int_req,
  // Program memory read port
  output logic [cpm_pkg::PM_AW-1:0] pm_addr,
  input wire logic [cpm_pkg::PM_DW-1:0] pm_rdata,
  // Data memory port
  output logic [cpm_pkg::DM_AW-1:0] dm_addr,
  output logic dm_re,
  output logic dm_we,
  output logic [cpm_pkg::ACC_W-1:0] dm_wdata,
  input wire logic [cpm_pkg::ACC_W-1:0] dm_rdata,
  // System outputs
  output logic soft_reset,
  output logic irq
);

  import cpm_pkg::*;

  typedef struct packed {
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic wr_pend;
    logic [BUS_AW-1:0] wr_addr;
    logic [PC_W-1:0] pc;
    logic [PTR_W-1:0] ptr0;
    logic [PTR_W-1:0] ptr1;
    logic [ACC_W-1:0] accum;
    logic [ACC_W-1:0] sh_accum;
    logic [PTR_W-1:0] sh_ptr0;
    logic [PTR_W-1:0] sh_ptr1;
    logic [SP_W-1:0] sp;
    logic ovf;
    logic unf;
    logic stkrst_en;
    logic gie;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
    cpm_state_type fsm;
    logic [PM_AW-1:0] pm_addr;
    logic [DM_AW-1:0] dm_addr;
    logic dm_re;
    logic dm_we;
    logic [ACC_W-1:0] dm_wdata;
    logic soft_reset;
    logic stk_we;
    logic [STACK_AW-1:0] stk_waddr;
    logic [PC_W-1:0] stk_wdata;
    logic [STACK_AW-1:0] stk_raddr;
  } cpm_core_state_type;

  localparam cpm_core_state_type S_RESET = '{
    hreadyout: 1'b1,
    pc: RESET_VECTOR,
    fsm: ST_IDLE,
    default: '0
  };

  cpm_core_state_type s;
  cpm_core_state_type next;

  logic [PC_W-1:0] stk_rdata;
  logic cmd_go;
  logic [PTR_W-1:0] cmd_ptr;
  logic [PC_W-1:0] opnd_pc;
  logic [1:0] stk_set;
  logic [1:0] pwr_clr;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic do_push;
  logic do_pop;
  logic [PC_W-1:0] push_val;

  // Map a pointer value onto the data memory address space
  function automatic logic [DM_AW-1:0] map_ptr(input logic [PTR_W-1:0] ptr);
    logic [PTR_W-1:0] lin;
    logic [PTR_W-1:0] bank;
    logic [PTR_W-1:0] offs;
    lin = ptr - LIN_BASE;
    bank = lin / GPR_BYTES;
    offs = lin % GPR_BYTES;
    if (ptr >= LIN_BASE && ptr < LIN_END) begin
      map_ptr = {bank[4:0], GPR_START + offs[6:0]}; // RULE7
    end else begin
      map_ptr = ptr[DM_AW-1:0];
    end
  endfunction

  // Return stack storage lives outside data memory
  cpm_stack_mem #(
    .DEPTH(STACK_DEPTH),
    .WIDTH(PC_W),
    .AW(STACK_AW)
  ) u_stack ( // RULE1
    .hclk(hclk),
    .hresetn(hresetn),
    .we(s.stk_we),
    .waddr(s.stk_waddr),
    .wdata(s.stk_wdata),
    .raddr(s.stk_raddr),
    .rdata(stk_rdata)
  );

  always_comb begin
    next = s;
    cmd_go = 1'b0;
    cmd_ptr = hwdata[CMD_SEL] ? s.ptr1 : s.ptr0; // RULE5
    opnd_pc = hwdata[CMD_OPND +: PC_W];
    stk_set = '0;
    pwr_clr = '0;
    irq_set = '0;
    irq_clr = '0;
    do_push = 1'b0;
    do_pop = 1'b0;
    push_val = s.pc;
    next.wr_pend = 1'b0;
    next.stk_we = 1'b0;
    next.dm_re = 1'b0;
    next.dm_we = 1'b0;
    next.soft_reset = 1'b0;

    // Address phase: read data is prepared now so it stands in the data phase
    if (hsel && htrans[1] && hready && hsize == SIZE_WORD) begin
      next.wr_pend = hwrite;
      next.wr_addr = haddr;
      // A write leaves the last read data standing
      if (!hwrite) begin
        unique case (haddr)
          OFF_CTRL: next.hrdata = 32'({s.gie, s.stkrst_en});
          OFF_PC: next.hrdata = 32'(s.pc); // RULE8
          OFF_PTR0: next.hrdata = 32'(s.ptr0);
          OFF_PTR1: next.hrdata = 32'(s.ptr1);
          OFF_ACCUM: next.hrdata = 32'(s.accum);
          OFF_PWRCON: next.hrdata = 32'({s.ovf, s.unf});
          OFF_STACK: next.hrdata = 32'({s.fsm != ST_IDLE, 3'h0, s.sp});
          OFF_IRQ_STATUS: next.hrdata = 32'(s.irq_status);
          OFF_IRQ_MASK: next.hrdata = 32'(s.irq_mask);
          OFF_SHADOW: next.hrdata = {s.sh_ptr1[7:0], s.sh_ptr0[7:0], 8'h00, s.sh_accum};
          OFF_INFO: next.hrdata = 32'(INSTR_COUNT); // RULE11
          default: next.hrdata = '0;
        endcase
      end
    end

    // Data phase of a write
    if (s.wr_pend) begin
      unique case (s.wr_addr)
        OFF_CTRL: begin
          next.stkrst_en = hwdata[CTRL_STKRST];
          next.gie = hwdata[CTRL_GIE];
        end
        OFF_CMD: cmd_go = (s.fsm == ST_IDLE);
        OFF_PTR0: next.ptr0 = hwdata[PTR_W-1:0];
        OFF_PTR1: next.ptr1 = hwdata[PTR_W-1:0];
        OFF_ACCUM: next.accum = hwdata[ACC_W-1:0];
        OFF_PWRCON: pwr_clr = hwdata[1:0];
        OFF_IRQ_STATUS: irq_clr = hwdata[IRQ_W-1:0];
        OFF_IRQ_MASK: next.irq_mask = hwdata[IRQ_W-1:0];
        default: ;
      endcase
    end

    // Multi-cycle operations finishing
    unique case (s.fsm)
      ST_IDLE: ;
      ST_POPA: next.fsm = ST_POPB;
      ST_POPB: begin
        next.pc = stk_rdata;
        next.fsm = ST_IDLE;
        irq_set[IRQ_DONE] = 1'b1;
      end
      ST_DMWAIT: begin
        next.accum = dm_rdata;
        next.fsm = ST_IDLE;
        irq_set[IRQ_DONE] = 1'b1;
      end
      // The program word needs a second cycle before it is taken
      ST_PMEXTRA: next.fsm = ST_PMWAIT; // RULE6
      ST_PMWAIT: begin
        next.accum = pm_rdata[ACC_W-1:0]; // RULE13
        next.fsm = ST_IDLE;
        irq_set[IRQ_DONE] = 1'b1;
      end
    endcase

    if (cmd_go) begin
      unique case (cpm_op_type'(hwdata[3:0]))
        OP_NOP: ;
        OP_STEP: next.pc = s.pc + 15'h1;
        OP_GOTO: next.pc = opnd_pc;
        OP_BRANCH: next.pc = s.pc + 15'h1 + opnd_pc; // RULE12
        OP_CALL: begin
          do_push = 1'b1;
          push_val = s.pc + 15'h1;
          next.pc = opnd_pc;
        end
        OP_RETURN: do_pop = 1'b1;
        OP_RETFIE: begin
          do_pop = 1'b1;
          next.accum = s.sh_accum; // RULE4
          next.ptr0 = s.sh_ptr0; // RULE4
          next.ptr1 = s.sh_ptr1; // RULE4
          next.gie = 1'b1;
        end
        OP_READ_DIRECT: begin
          next.dm_addr = hwdata[CMD_OPND +: DM_AW]; // RULE12
          next.dm_re = 1'b1;
          next.fsm = ST_DMWAIT;
        end
        OP_WRITE_DIRECT: begin
          next.dm_addr = hwdata[CMD_OPND +: DM_AW];
          next.dm_we = 1'b1;
          next.dm_wdata = s.accum;
        end
        OP_READ_IND: begin
          if (cmd_ptr[PM_SEL_BIT]) begin
            next.pm_addr = cmd_ptr[PM_AW-1:0]; // RULE9
            next.fsm = ST_PMEXTRA; // RULE6
          end else begin
            next.dm_addr = map_ptr(cmd_ptr); // RULE12
            next.dm_re = 1'b1;
            next.fsm = ST_DMWAIT;
          end
        end
        OP_WRITE_IND: begin
          // Program memory is read-only through the pointers
          if (!cmd_ptr[PM_SEL_BIT]) begin // RULE14
            next.dm_addr = map_ptr(cmd_ptr);
            next.dm_we = 1'b1;
            next.dm_wdata = s.accum;
          end
        end
        OP_PTR_ADD: begin
          if (hwdata[CMD_SEL]) begin
            next.ptr1 = s.ptr1 + hwdata[CMD_OPND +: PTR_W];
          end else begin
            next.ptr0 = s.ptr0 + hwdata[CMD_OPND +: PTR_W];
          end
        end
        default: irq_set[IRQ_ILLEGAL] = 1'b1;
      endcase
    end

    // Interrupt entry only when no command is being taken
    if (s.fsm == ST_IDLE && !cmd_go && s.gie && int_req) begin
      do_push = 1'b1;
      push_val = s.pc;
      next.pc = INT_VECTOR; // RULE10
      next.sh_accum = s.accum; // RULE4
      next.sh_ptr0 = s.ptr0; // RULE4
      next.sh_ptr1 = s.ptr1; // RULE4
      next.gie = 1'b0;
      irq_set[IRQ_INT] = 1'b1;
    end

    if (do_push) begin
      if (s.sp == SP_W'(STACK_DEPTH)) begin
        stk_set[PWR_OVF] = 1'b1; // RULE2
      end else begin
        next.stk_we = 1'b1;
        next.stk_waddr = s.sp[STACK_AW-1:0];
        next.stk_wdata = push_val;
        next.sp = s.sp + 5'h1;
      end
    end

    if (do_pop) begin
      if (s.sp == '0) begin
        stk_set[PWR_UNF] = 1'b1; // RULE2
      end else begin
        next.sp = s.sp - 5'h1;
        next.stk_raddr = STACK_AW'(s.sp - 5'h1);
        next.fsm = ST_POPA;
      end
    end

    if (cmd_go && next.fsm == ST_IDLE) begin
      irq_set[IRQ_DONE] = 1'b1;
    end

    // A stack error restarts the core but keeps the flags for software
    if (stk_set != '0 && s.stkrst_en) begin // RULE3
      next.soft_reset = 1'b1;
      next.pc = RESET_VECTOR; // RULE10
      next.sp = '0;
      next.fsm = ST_IDLE;
      next.gie = 1'b0;
      next.stk_we = 1'b0;
      next.dm_re = 1'b0;
      next.dm_we = 1'b0;
    end

    // Hardware set wins over a same-cycle software clear
    next.unf = (s.unf & ~pwr_clr[PWR_UNF]) | stk_set[PWR_UNF]; // RULE2
    next.ovf = (s.ovf & ~pwr_clr[PWR_OVF]) | stk_set[PWR_OVF]; // RULE2
    irq_set[IRQ_OVF] = irq_set[IRQ_OVF] | stk_set[PWR_OVF];
    irq_set[IRQ_UNF] = irq_set[IRQ_UNF] | stk_set[PWR_UNF];
    next.irq_status = (s.irq_status & ~irq_clr) | irq_set;
    next.irq = |(next.irq_status & next.irq_mask);

    // Upper counter bits are dropped so the fetch wraps inside 4K words
    if (next.fsm != ST_PMEXTRA && next.fsm != ST_PMWAIT) begin
      next.pm_addr = next.pc[PM_AW-1:0]; // RULE9 RULE15
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= S_RESET; // RULE10
    end else begin
      s <= next;
    end
  end

  assign hreadyout = s.hreadyout;
  assign hresp = s.hresp;
  assign hrdata = s.hrdata;
  assign pm_addr = s.pm_addr;
  assign dm_addr = s.dm_addr;
  assign dm_re = s.dm_re;
  assign dm_we = s.dm_we;
  assign dm_wdata = s.dm_wdata;
  assign soft_reset = s.soft_reset;
  assign irq = s.irq;

endmodule // cpm_core

`default_nettype wire

// *** cpm_pkg.sv ***
// Constants, field positions and enumerations shared by the core addressing block
`default_nettype none

package cpm_pkg;

  // Widths
  localparam int BUS_AW = 8;
  localparam int PC_W = 15;
  localparam int PM_AW = 12;
  localparam int PM_DW = 14;
  localparam int DM_AW = 12;
  localparam int PTR_W = 16;
  localparam int ACC_W = 8;
  localparam int STACK_DEPTH = 16;
  localparam int STACK_AW = 4;
  localparam int SP_W = 5;
  localparam int IRQ_W = 5;

  // Vectors and memory map
  localparam logic [14:0] RESET_VECTOR = 15'h0000;
  localparam logic [14:0] INT_VECTOR = 15'h0004;
  localparam logic [11:0] PM_LAST = 12'hFFF;
  localparam logic [15:0] LIN_BASE = 16'h2000;
  localparam logic [15:0] LIN_END = 16'h29B0;
  localparam logic [15:0] GPR_BYTES = 16'h0050;
  localparam logic [6:0] GPR_START = 7'h20;
  localparam int PM_SEL_BIT = 15;
  localparam logic [7:0] INSTR_COUNT = 8'h31;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CMD = 8'h04;
  localparam logic [7:0] OFF_PC = 8'h08;
  localparam logic [7:0] OFF_PTR0 = 8'h0C;
  localparam logic [7:0] OFF_PTR1 = 8'h10;
  localparam logic [7:0] OFF_ACCUM = 8'h14;
  localparam logic [7:0] OFF_PWRCON = 8'h18;
  localparam logic [7:0] OFF_STACK = 8'h1C;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h20;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h24;
  localparam logic [7:0] OFF_SHADOW = 8'h28;
  localparam logic [7:0] OFF_INFO = 8'h2C;

  // Field positions
  localparam int CTRL_STKRST = 0;
  localparam int CTRL_GIE = 1;
  localparam int CMD_SEL = 8;
  localparam int CMD_OPND = 16;
  localparam int PWR_UNF = 0;
  localparam int PWR_OVF = 1;
  localparam int STK_BUSY = 8;
  localparam int IRQ_OVF = 0;
  localparam int IRQ_UNF = 1;
  localparam int IRQ_INT = 2;
  localparam int IRQ_DONE = 3;
  localparam int IRQ_ILLEGAL = 4;

  // Bus encodings
  localparam logic [2:0] SIZE_WORD = 3'h2;

  typedef enum logic [2:0] {
    ST_IDLE, ST_POPA, ST_POPB, ST_DMWAIT, ST_PMEXTRA, ST_PMWAIT
  } cpm_state_type;

  typedef enum logic [3:0] {
    OP_NOP, OP_STEP, OP_GOTO, OP_BRANCH, OP_CALL, OP_RETURN, OP_RETFIE,
    OP_READ_DIRECT, OP_WRITE_DIRECT, OP_READ_IND, OP_WRITE_IND, OP_PTR_ADD
  } cpm_op_type;

endpackage

`default_nettype wire

// *** cpm_stack_mem.sv ***
// Return address memory with registered read data
`default_nettype none

module cpm_stack_mem #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 15,
  parameter int AW = 4
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  // Read port
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] words;
    logic [WIDTH-1:0] rdata;
  } cpm_stack_mem_state_type;

  cpm_stack_mem_state_type s;
  cpm_stack_mem_state_type next;

  always_comb begin
    next = s;
    if (we) begin
      next.words[waddr] = wdata;
    end
    // Read sees the old word on a same-cycle write to the same entry
    next.rdata = s.words[raddr];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next;
    end
  end

  assign rdata = s.rdata;

endmodule // cpm_stack_mem

`default_nettype wire

// *** cpm_core_assertions.sv ***
// Port-level assertions for the core addressing block
`default_nettype none

module cpm_core_assertions (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  // Core
  input wire logic [11:0] pm_addr,
  input wire logic dm_re,
  input wire logic dm_we,
  input wire logic soft_reset,
  input wire logic irq
);
  logic rd_phase;

  assign rd_phase = hsel && htrans[1] && !hwrite;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus stalled or answered with error");
  a_reset_vector: assert property ($rose(hresetn) |-> pm_addr == 12'h000 && !irq)
    else $error("fetch did not start at zero");
  a_soft_pulse: assert property (soft_reset |=> !soft_reset)
    else $error("soft reset longer than one cycle");
  a_soft_vector: assert property (soft_reset |-> ##[0:1] pm_addr == 12'h000)
    else $error("soft reset did not restart fetch");
  a_read_pulse: assert property (dm_re |=> !dm_re)
    else $error("data read strobe too long");
  a_write_pulse: assert property (dm_we |=> !dm_we)
    else $error("data write strobe too long");
  a_mem_excl: assert property (!(dm_re && dm_we))
    else $error("read and write strobes together");
  // Read data may only move after a read address phase
  a_rdata_hold: assert property (!$stable(hrdata) |-> $past(rd_phase))
    else $error("read data changed without a read");
endmodule // cpm_core_assertions

bind cpm_core cpm_core_assertions u_chk (
  .hclk(hclk),
  .hresetn(hresetn),
  .hsel(hsel),
  .htrans(htrans),
  .hwrite(hwrite),
  .hreadyout(hreadyout),
  .hrdata(hrdata),
  .hresp(hresp),
  .pm_addr(pm_addr),
  .dm_re(dm_re),
  .dm_we(dm_we),
  .soft_reset(soft_reset),
  .irq(irq)
);

`default_nettype wire

// *** test_cpu_core_program_memory_stack.sv ***
// Register-level testbench for the core addressing block
`default_nettype none

module test_cpu_core_program_memory_stack;
  timeunit 1ns;
  timeprecision 1ps;
  import cpm_pkg::*;

  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, int_req;
  logic dm_re, dm_we, soft_reset, irq;
  logic [7:0] haddr, dm_wdata, dm_rdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic [11:0] pm_addr, dm_addr;
  logic [11:0] last_dm = 12'h000;
  logic [19:0] last_wr = 20'h00000;
  logic [13:0] pm_rdata;
  int errors = 0, check_count = 0, soft_cnt = 0, we_cnt = 0;

  // Memories answer with a pattern of the address, so a wrong address shows
  assign pm_rdata = {2'b10, ~pm_addr};
  assign dm_rdata = dm_addr[7:0] ^ 8'hA5;

  cpm_core DUT (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hreadyout),
    .hwdata(hwdata),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .hresp(hresp),
    .int_req(int_req),
    .pm_addr(pm_addr),
    .pm_rdata(pm_rdata),
    .dm_addr(dm_addr),
    .dm_re(dm_re),
    .dm_we(dm_we),
    .dm_wdata(dm_wdata),
    .dm_rdata(dm_rdata),
    .soft_reset(soft_reset),
    .irq(irq)
  );

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    if (dm_re) last_dm <= dm_addr;
    if (dm_we) we_cnt <= we_cnt + 1;
    if (dm_we) last_wr <= {dm_addr, dm_wdata};
    if (soft_reset) soft_cnt <= soft_cnt + 1;
  end

  task automatic wrap_up;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      wrap_up;
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= SIZE_WORD;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    rd = hrdata;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(rd, e);
  endtask

  // A command is written, then busy is polled until it has dropped
  task automatic cmd(input logic [3:0] op, input logic sel, input logic [15:0] v);
    int n;
    n = 0;
    bus(1'b1, OFF_CMD, {v, 7'h00, sel, 4'h0, op});
    do begin
      bus(1'b0, OFF_STACK, 32'h0);
      n++;
    end while (rd[STK_BUSY] !== 1'b0 && n < 50);
    if (n >= 50) begin
      errors++;
      wrap_up;
    end
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h0;
    int_req = 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk(OFF_PC, 32'h0);
    rchk(OFF_STACK, 32'h0);
    rchk(OFF_INFO, 32'h31);
    rchk(8'h30, 32'h0);
    cmd(OP_GOTO, 1'b0, 16'h7FFF);
    rchk(OFF_PC, 32'h7FFF);
    check({20'h0, pm_addr}, 32'hFFF);
    cmd(OP_STEP, 1'b0, 16'h0);
    check({20'h0, pm_addr}, 32'h0);
    for (int i = 0; i < 16; i++) cmd(OP_CALL, 1'b0, 16'h0100 + 16'(i));
    rchk(OFF_STACK, 32'h10);
    cmd(OP_CALL, 1'b0, 16'h0200);
    rchk(OFF_PWRCON, 32'h2);
    bus(1'b1, OFF_PWRCON, 32'h2);
    for (int j = 15; j >= 0; j--) begin
      cmd(OP_RETURN, 1'b0, 16'h0);
      rchk(OFF_PC, (j == 0) ? 32'h1 : 32'h100 + j);
    end
    cmd(OP_RETURN, 1'b0, 16'h0);
    rchk(OFF_PWRCON, 32'h1);
    rchk(OFF_PC, 32'h1);
    check(32'(soft_cnt), 32'h0);
    bus(1'b1, OFF_PTR1, 32'h2050);
    cmd(OP_READ_IND, 1'b1, 16'h0);
    check({20'h0, last_dm}, 32'h0A0);
    rchk(OFF_ACCUM, 32'h05);
    bus(1'b1, OFF_PTR0, 32'h8123);
    // Program word read: fetch address must stand one cycle longer than a data read
    bus(1'b1, OFF_CMD, {16'h0, 7'h00, 1'b0, 4'h0, OP_READ_IND});
    @(negedge hclk);
    check({20'h0, pm_addr}, 32'h123);
    @(negedge hclk);
    check({20'h0, pm_addr}, 32'h123);
    @(negedge hclk);
    check({20'h0, pm_addr}, 32'h001);
    @(posedge hclk);
    rchk(OFF_ACCUM, 32'hDC);
    cmd(OP_WRITE_IND, 1'b0, 16'h0);
    check(32'(we_cnt), 32'h0);
    cmd(OP_PTR_ADD, 1'b0, 16'h8000);
    rchk(OFF_PTR0, 32'h0123);
    cmd(OP_BRANCH, 1'b0, 16'h1233);
    rchk(OFF_PC, 32'h1235);
    check({20'h0, pm_addr}, 32'h235);
    cmd(OP_WRITE_DIRECT, 1'b0, 16'h0077);
    check({12'h0, last_wr}, 32'h077DC);
    cmd(OP_WRITE_IND, 1'b0, 16'h0);
    check(32'(we_cnt), 32'h2);
    check({12'h0, last_wr}, 32'h123DC);
    cmd(OP_READ_DIRECT, 1'b0, 16'h0042);
    check({20'h0, last_dm}, 32'h042);
    rchk(OFF_ACCUM, 32'hE7);
    bus(1'b1, OFF_IRQ_STATUS, 32'h1F);
    cmd(4'hC, 1'b0, 16'h0);
    rchk(OFF_IRQ_STATUS, 32'h18);
    cmd(OP_GOTO, 1'b0, 16'h0055);
    bus(1'b1, OFF_IRQ_STATUS, 32'h1F);
    bus(1'b1, OFF_IRQ_MASK, 32'h4);
    bus(1'b1, OFF_ACCUM, 32'h5A);
    bus(1'b1, OFF_PTR0, 32'h1234);
    bus(1'b1, OFF_CTRL, 32'h2);
    int_req <= 1'b1;
    repeat (3) @(posedge hclk);
    int_req <= 1'b0;
    rchk(OFF_PC, 32'h4);
    rchk(OFF_IRQ_STATUS, 32'h4);
    check({31'h0, irq}, 32'h1);
    rchk(OFF_SHADOW, 32'h5034005A);
    bus(1'b1, OFF_ACCUM, 32'h0);
    bus(1'b1, OFF_PTR0, 32'h0);
    cmd(OP_RETFIE, 1'b0, 16'h0);
    rchk(OFF_ACCUM, 32'h5A);
    rchk(OFF_PTR0, 32'h1234);
    rchk(OFF_PC, 32'h55);
    // Irq is registered from the new mask on the same edge as the mask, yet let two edges pass
    bus(1'b1, OFF_IRQ_MASK, 32'h0);
    repeat (2) @(posedge hclk);
    check({31'h0, irq}, 32'h0);
    bus(1'b1, OFF_IRQ_STATUS, 32'h1F);
    rchk(OFF_IRQ_STATUS, 32'h0);
    // Flags cleared first, so the final read shows a flag set by this error
    bus(1'b1, OFF_PWRCON, 32'h3);
    rchk(OFF_PWRCON, 32'h0);
    bus(1'b1, OFF_CTRL, 32'h1);
    cmd(OP_RETURN, 1'b0, 16'h0);
    check(32'(soft_cnt), 32'h1);
    rchk(OFF_PC, 32'h0);
    rchk(OFF_PWRCON, 32'h1);
    wrap_up;
  end
endmodule // test_cpu_core_program_memory_stack

`default_nettype wire
